// [rtl/can_irq_pkg.sv]
package can_irq_pkg;
    // Byte offsets on the register bus
    localparam logic [7:0] MASTER_CTRL_ADDR = 8'h00;
    localparam logic [7:0] GLOBAL_STAT_ADDR = 8'h04;
    localparam logic [7:0] IRQ_REQ_ADDR = 8'h08;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h0C;
    localparam logic [7:0] MBOX_MASK_ADDR = 8'h10;
    localparam logic [7:0] RX_PEND_ADDR = 8'h14;
    localparam logic [7:0] REMOTE_PEND_ADDR = 8'h18;
    localparam logic [7:0] CTRL_FIELD_BASE = 8'h40;
    localparam logic [7:0] MBOX_DATA_BASE = 8'h80;
    localparam logic [7:0] MBOX_AREA_END = 8'hC0;
    // Master control bits
    localparam int SOFT_RESET_POS = 0;
    localparam int TEST_MODE_POS = 1;
    // Interrupt request flag positions
    localparam int RESET_HALT_POS = 0;
    localparam int DATA_RX_POS = 1;
    localparam int REMOTE_RX_POS = 2;
    localparam int TX_WARN_POS = 3;
    localparam int RX_WARN_POS = 4;
    localparam int PASSIVE_POS = 5;
    localparam int BUS_OFF_POS = 6;
    localparam int OVERLOAD_POS = 7;
    localparam int SLOT_EMPTY_POS = 8;
    localparam int OVERRUN_POS = 9;
    localparam int SLEEP_ACT_POS = 12;
    localparam int MSG_ERR_POS = 13;
    // Grouping of flags onto request lines
    localparam logic [15:0] ERR_GROUP = 16'h0078;
    localparam logic [15:0] OVR_GROUP = 16'h3281;
    localparam logic [15:0] SLE_GROUP = 16'h0100;
    // Reset values
    localparam logic [15:0] FLAGS_RESET = 16'h0001;
    localparam logic [15:0] IRQ_MASK_RESET = 16'hFFFF;
    localparam logic [15:0] MBOX_MASK_RESET = 16'hFFFF;
    localparam logic [15:0] CTRL_FIELD_RESET = 16'h0000;
    localparam logic [1:0] MASTER_CTRL_RESET = 2'b00;
    // Error counter thresholds
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
    // Longest stall on a mailbox access during frame storage
    localparam logic [2:0] MAX_WAIT = 3'h5;
endpackage

// [rtl/can_irq_reset_ctrl.sv]
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
// Contract
// RQ1: Error passive flag sets when either error count reaches 128.
// RQ2: Bus off flag sets at transmit count 256 and on recovery.
// RQ3: Transmit warning flag sets at transmit count 96.
// RQ4: Receive warning flag sets at receive count 96.
// RQ5: Five flags feed the overrun group line.
// RQ6: Message error flag only rises in test mode.
// RQ7: Slot empty line comes from the slot empty flag.
// RQ8: Mailbox 0 pending drives one receive line, mailboxes 1-15 the other.
// RQ9: Summary flags for data and remote reception over all mailboxes.
// RQ10: All sources maskable except the power-on reset flag.
// RQ11: Only the mailbox zero receive line may start DMA.
// RQ12: DMA clearing reads mailbox 0 through control field one, block mode; here no read clears dma_request, only software clears or masks.
// RQ13: Power-on reset and standby entry fully initialise the block.
// RQ14: Soft reset clears all but master control, and resets communication.
// RQ15: Reset-processing flag set at any reset; software clears it.
// RQ16: Mailbox storage beyond control field one is not reset.
// RQ17: In CAN sleep software touches only four registers.
// RQ18: Mailbox access during frame storage waits 0 to 5 cycles.
// RQ19: Software waits for the module clock before register access.
// RQ20: Slot empty flag sets on any transmit or abort acknowledge.
// RQ21: Each line is high while a grouped unmasked flag is set.
module can_irq_reset_ctrl #(
    parameter int MAILBOXES = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic standby_entry,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [8:0] tx_error_count,
    input wire logic [7:0] rx_error_count,
    input wire logic bus_off_recovered,
    input wire logic reset_halt_sleep_event,
    input wire logic overload_sent,
    input wire logic overrun_event,
    input wire logic sleep_bus_activity,
    input wire logic message_error_event,
    input wire logic rx_store_busy,
    input wire logic [MAILBOXES-1:0] tx_ack_bits,
    input wire logic [MAILBOXES-1:0] abort_ack_bits,
    input wire logic [MAILBOXES-1:0] rx_data_set,
    input wire logic [MAILBOXES-1:0] rx_remote_set,
    output logic error_status_irq,
    output logic overrun_group_irq,
    output logic slot_empty_irq,
    output logic mailbox_zero_rx_irq,
    output logic other_mailbox_rx_irq,
    output logic dma_request,
    output logic comm_reset,
    output logic test_mode
);
    import can_irq_pkg::*;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    function automatic logic [15:0] lanes16(input logic [31:0] v, input logic [3:0] sel);
        lanes16 = {sel[1] ? v[15:8] : 8'h00, sel[0] ? v[7:0] : 8'h00};
    endfunction

    // ==========================================================
    // Bus slave
    logic [1:0] master_ctrl_reg;
    logic soft_reset_reg;
    logic [15:0] flags_reg;
    logic [15:0] irq_mask_reg;
    logic [MAILBOXES-1:0] mbox_mask_reg;
    logic [MAILBOXES-1:0] rx_pend_reg;
    logic [MAILBOXES-1:0] remote_pend_reg;
    logic [15:0] ctrl_field_reg [MAILBOXES];
    logic [15:0] mbox_data_reg [MAILBOXES];
    logic por_flag_reg;
    logic [2:0] wait_reg;
    logic wb_ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic tx_warn_prev, rx_warn_prev, passive_prev, bus_off_prev;

    wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
    wire logic in_mbox = (wb_adr_i >= CTRL_FIELD_BASE) && (wb_adr_i < MBOX_AREA_END);
    wire logic in_ctrl = in_mbox && (wb_adr_i < MBOX_DATA_BASE);
    wire logic [3:0] mbox_idx = wb_adr_i[5:2];
    // Stall only while a received frame is landing, and never past the limit
    wire logic hold = req & in_mbox & rx_store_busy & (wait_reg < MAX_WAIT); // [RQ18]
    wire logic take = req & ~hold;
    wire logic do_write = take & wb_we_i;
    wire logic wipe = standby_entry | soft_reset_reg; // [RQ13] [RQ14]
    wire logic wr_flags = do_write && wb_adr_i == IRQ_REQ_ADDR;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            wait_reg <= 3'h0;
        else if (!req)
            wait_reg <= 3'h0;
        else if (hold)
            wait_reg <= wait_reg + 3'h1;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_reg <= take;
            if (take)
                rdata_reg <= rdata_next;
        end
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (in_ctrl)
            rdata_next[15:0] = ctrl_field_reg[mbox_idx];
        else if (in_mbox)
            rdata_next[15:0] = mbox_data_reg[mbox_idx];
        else
        begin
            unique case (wb_adr_i)
                MASTER_CTRL_ADDR: rdata_next[1:0] = master_ctrl_reg;
                GLOBAL_STAT_ADDR: rdata_next[3:0] = {bus_off_prev, passive_prev,
                                                     rx_warn_prev, tx_warn_prev};
                IRQ_REQ_ADDR: rdata_next[15:0] = flags_reg | {13'h0000,
                    |remote_pend_reg, |rx_pend_reg, 1'b0}; // [RQ9]
                IRQ_MASK_ADDR: rdata_next[15:0] = irq_mask_reg;
                MBOX_MASK_ADDR: rdata_next[15:0] = mbox_mask_reg;
                RX_PEND_ADDR: rdata_next[15:0] = rx_pend_reg;
                REMOTE_PEND_ADDR: rdata_next[15:0] = remote_pend_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Master control and resets
    // The master control register survives its own soft reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            master_ctrl_reg <= MASTER_CTRL_RESET;
            soft_reset_reg <= 1'b0;
        end
        else if (standby_entry)
        begin
            master_ctrl_reg <= MASTER_CTRL_RESET; // [RQ13]
            soft_reset_reg <= 1'b0;
        end
        else
        begin
            soft_reset_reg <= do_write && wb_adr_i == MASTER_CTRL_ADDR && wb_sel_i[0]
                              && wb_dat_i[SOFT_RESET_POS]; // [RQ14]
            if (do_write && wb_adr_i == MASTER_CTRL_ADDR && wb_sel_i[0])
                master_ctrl_reg <= {wb_dat_i[TEST_MODE_POS], 1'b0};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            comm_reset <= 1'b1;
        else
            comm_reset <= wipe; // [RQ14]
    end

    // ==========================================================
    // Masks and mailbox control fields
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_mask_reg <= IRQ_MASK_RESET;
            mbox_mask_reg <= MBOX_MASK_RESET;
            for (int i = 0; i < MAILBOXES; i++)
                ctrl_field_reg[i] <= CTRL_FIELD_RESET;
        end
        else if (wipe)
        begin
            irq_mask_reg <= IRQ_MASK_RESET;
            mbox_mask_reg <= MBOX_MASK_RESET;
            for (int i = 0; i < MAILBOXES; i++)
                ctrl_field_reg[i] <= CTRL_FIELD_RESET;
        end
        else if (do_write)
        begin
            if (wb_adr_i == IRQ_MASK_ADDR)
                irq_mask_reg <= merge16(irq_mask_reg, wb_dat_i, wb_sel_i); // [RQ10]
            if (wb_adr_i == MBOX_MASK_ADDR)
                mbox_mask_reg <= merge16(mbox_mask_reg, wb_dat_i, wb_sel_i);
            if (in_ctrl)
                ctrl_field_reg[mbox_idx] <= merge16(ctrl_field_reg[mbox_idx], wb_dat_i,
                                                    wb_sel_i);
        end
    end

    // Mailbox payload is plain storage with no reset
    always_ff @(posedge sys_clk)
    begin
        if (do_write && in_mbox && !in_ctrl)
            mbox_data_reg[mbox_idx] <= merge16(mbox_data_reg[mbox_idx], wb_dat_i,
                                               wb_sel_i); // [RQ16]
    end

    // ==========================================================
    // Event flags
    wire logic tx_warn_lvl = tx_error_count >= WARN_LIMIT;
    wire logic rx_warn_lvl = {1'b0, rx_error_count} >= WARN_LIMIT;
    wire logic passive_lvl = tx_error_count >= PASSIVE_LIMIT
                             || {1'b0, rx_error_count} >= PASSIVE_LIMIT;
    wire logic bus_off_lvl = tx_error_count >= BUS_OFF_LIMIT;
    logic [15:0] set_vec;
    wire logic [15:0] clr_vec = wr_flags ? lanes16(wb_dat_i, wb_sel_i) : 16'h0000;

    always_comb
    begin
        set_vec = 16'h0000;
        set_vec[TX_WARN_POS] = tx_warn_lvl & ~tx_warn_prev; // [RQ3]
        set_vec[RX_WARN_POS] = rx_warn_lvl & ~rx_warn_prev; // [RQ4]
        set_vec[PASSIVE_POS] = passive_lvl & ~passive_prev; // [RQ1]
        set_vec[BUS_OFF_POS] = (bus_off_lvl & ~bus_off_prev) | bus_off_recovered; // [RQ2]
        set_vec[RESET_HALT_POS] = reset_halt_sleep_event; // [RQ5]
        set_vec[OVERLOAD_POS] = overload_sent; // [RQ5]
        set_vec[OVERRUN_POS] = overrun_event; // [RQ5]
        set_vec[SLEEP_ACT_POS] = sleep_bus_activity; // [RQ5]
        set_vec[MSG_ERR_POS] = message_error_event & master_ctrl_reg[TEST_MODE_POS]; // [RQ6]
        set_vec[SLOT_EMPTY_POS] = |(tx_ack_bits | abort_ack_bits); // [RQ20]
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_warn_prev <= 1'b0;
            rx_warn_prev <= 1'b0;
            passive_prev <= 1'b0;
            bus_off_prev <= 1'b0;
        end
        else
        begin
            tx_warn_prev <= tx_warn_lvl;
            rx_warn_prev <= rx_warn_lvl;
            passive_prev <= passive_lvl;
            bus_off_prev <= bus_off_lvl;
        end
    end

    // A set in the same cycle as a software clear wins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_reg <= FLAGS_RESET; // [RQ15]
        else if (wipe)
            flags_reg <= FLAGS_RESET; // [RQ15]
        else
            flags_reg <= (flags_reg & ~clr_vec) | set_vec;
    end

    // Marks that the reset flag came from power-on and so ignores its mask
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            por_flag_reg <= 1'b1;
        else if (wr_flags && clr_vec[RESET_HALT_POS])
            por_flag_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_pend_reg <= '0;
            remote_pend_reg <= '0;
        end
        else if (wipe)
        begin
            rx_pend_reg <= '0;
            remote_pend_reg <= '0;
        end
        else
        begin
            rx_pend_reg <= (rx_pend_reg & ~((do_write && wb_adr_i == RX_PEND_ADDR)
                ? lanes16(wb_dat_i, wb_sel_i) : 16'h0000)) | rx_data_set; // [RQ9]
            remote_pend_reg <= (remote_pend_reg & ~((do_write && wb_adr_i ==
                REMOTE_PEND_ADDR) ? lanes16(wb_dat_i, wb_sel_i) : 16'h0000))
                | rx_remote_set; // [RQ9]
        end
    end

    // ==========================================================
    // Request lines
    wire logic [15:0] mask_eff = irq_mask_reg & ~{15'h0000, por_flag_reg}; // [RQ10]
    wire logic [15:0] live = flags_reg & ~mask_eff;
    wire logic [MAILBOXES-1:0] rx_live = ((rx_pend_reg & ~{MAILBOXES{irq_mask_reg[DATA_RX_POS]}})
        | (remote_pend_reg & ~{MAILBOXES{irq_mask_reg[REMOTE_RX_POS]}})) & ~mbox_mask_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            error_status_irq <= 1'b0;
            overrun_group_irq <= 1'b0;
            slot_empty_irq <= 1'b0;
            mailbox_zero_rx_irq <= 1'b0;
            other_mailbox_rx_irq <= 1'b0;
            dma_request <= 1'b0;
        end
        else
        begin
            error_status_irq <= |(live & ERR_GROUP); // [RQ21]
            overrun_group_irq <= |(live & OVR_GROUP); // [RQ5] [RQ21]
            slot_empty_irq <= |(live & SLE_GROUP); // [RQ7]
            mailbox_zero_rx_irq <= rx_live[0]; // [RQ8]
            other_mailbox_rx_irq <= |rx_live[MAILBOXES-1:1]; // [RQ8]
            dma_request <= rx_live[0]; // [RQ11]
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = rdata_reg;
    assign test_mode = master_ctrl_reg[TEST_MODE_POS];

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_tx_warn_set: assert property (tx_warn_lvl && !tx_warn_prev && !wipe |=> flags_reg[TX_WARN_POS]) // [RQ3]
        else $error("tx warning flag missed");
    chk_rx_warn_set: assert property (rx_warn_lvl && !rx_warn_prev && !wipe |=> flags_reg[RX_WARN_POS]) // [RQ4]
        else $error("rx warning flag missed");
    chk_passive_set: assert property (passive_lvl && !passive_prev && !wipe |=> flags_reg[PASSIVE_POS]) // [RQ1]
        else $error("error passive flag missed");
    chk_bus_off_set: assert property (bus_off_recovered && !wipe |=> flags_reg[BUS_OFF_POS]) // [RQ2]
        else $error("bus off flag missed");
    chk_msg_err_gate: assert property (!test_mode && !flags_reg[MSG_ERR_POS] |=> !flags_reg[MSG_ERR_POS]) // [RQ6]
        else $error("message error outside test mode");
    chk_slot_line: assert property (|(tx_ack_bits | abort_ack_bits) && !wipe && !irq_mask_reg[SLOT_EMPTY_POS] && !wr_flags && !do_write |=> ##1 slot_empty_irq) // [RQ7]
        else $error("slot empty line late");
    chk_dma_only_zero: assert property (dma_request == mailbox_zero_rx_irq) // [RQ11]
        else $error("dma request from wrong line");
    chk_wait_bound: assert property ($rose(req) |-> ##[1:6] wb_ack_o) // [RQ18]
        else $error("mailbox wait too long");
    chk_soft_reset: assert property (soft_reset_reg |=> flags_reg[RESET_HALT_POS] && irq_mask_reg == IRQ_MASK_RESET) // [RQ14]
        else $error("soft reset incomplete");
    chk_por_unmask: assert property (rst_n && por_flag_reg && flags_reg[RESET_HALT_POS] |=> overrun_group_irq) // [RQ10]
        else $error("power-on flag masked");
endmodule // can_irq_reset_ctrl
`default_nettype wire

// [dv/can_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Protocol engine stand-in
// Events are one-cycle pulses; counters and the store flag are levels
module can_engine_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_kind,
    input wire logic [8:0] cmd_arg,
    output logic [8:0] tx_error_count,
    output logic [7:0] rx_error_count,
    output logic [5:0] event_pulse,
    output logic rx_store_busy,
    output logic [15:0] tx_ack_bits,
    output logic [15:0] abort_ack_bits,
    output logic [15:0] rx_data_set,
    output logic [15:0] rx_remote_set
);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_error_count <= 9'h000;
            rx_error_count <= 8'h00;
            event_pulse <= 6'h00;
            rx_store_busy <= 1'b0;
            tx_ack_bits <= 16'h0000;
            abort_ack_bits <= 16'h0000;
            rx_data_set <= 16'h0000;
            rx_remote_set <= 16'h0000;
        end
        else
        begin
            event_pulse <= 6'h00;
            tx_ack_bits <= 16'h0000;
            abort_ack_bits <= 16'h0000;
            rx_data_set <= 16'h0000;
            rx_remote_set <= 16'h0000;
            if (cmd_valid)
            begin
                case (cmd_kind)
                    4'h6: tx_ack_bits[cmd_arg[3:0]] <= 1'b1;
                    4'h7: abort_ack_bits[cmd_arg[3:0]] <= 1'b1;
                    4'h8: rx_data_set[cmd_arg[3:0]] <= 1'b1;
                    4'h9: rx_remote_set[cmd_arg[3:0]] <= 1'b1;
                    4'hA: tx_error_count <= cmd_arg;
                    4'hB: rx_error_count <= cmd_arg[7:0];
                    4'hC: rx_store_busy <= cmd_arg[0];
                    default: event_pulse[cmd_kind[2:0]] <= 1'b1;
                endcase
            end
        end
    end
endmodule // can_engine_model
`default_nettype wire

// [dv/can_controller_interrupt_reset_logic_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module can_controller_interrupt_reset_logic_bench;
    import can_irq_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic standby_entry = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_kind = 4'h0;
    logic [8:0] cmd_arg = 9'h000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rx_store_busy, error_status_irq, overrun_group_irq, slot_empty_irq;
    logic mailbox_zero_rx_irq, other_mailbox_rx_irq, dma_request, comm_reset, test_mode;
    logic [8:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic [5:0] ev;
    logic [15:0] txa, aba, rxd, rxr;
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 32'h0437_c3b0;
    int flags, imask, mbmask, rxp, rmp, po, tm, txm, rxm, d, mb;
    int pay = -1;
    int bt[6] = '{95, 96, 127, 128, 256, 255};
    int br[6] = '{95, 96, 127, 0, 128, 200};
    int ebit[8] = '{0, 7, 9, 12, 13, 6, 8, 8};
    always #10 sys_clk = ~sys_clk;
    can_engine_model engine (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_arg(cmd_arg), .tx_error_count(tx_cnt),
        .rx_error_count(rx_cnt), .event_pulse(ev), .rx_store_busy(rx_store_busy),
        .tx_ack_bits(txa), .abort_ack_bits(aba), .rx_data_set(rxd), .rx_remote_set(rxr));
    can_irq_reset_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .standby_entry(standby_entry),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'h3), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_error_count(tx_cnt), .rx_error_count(rx_cnt), .bus_off_recovered(ev[5]),
        .reset_halt_sleep_event(ev[0]), .overload_sent(ev[1]), .overrun_event(ev[2]),
        .sleep_bus_activity(ev[3]), .message_error_event(ev[4]),
        .rx_store_busy(rx_store_busy), .tx_ack_bits(txa), .abort_ack_bits(aba),
        .rx_data_set(rxd), .rx_remote_set(rxr), .error_status_irq(error_status_irq),
        .overrun_group_irq(overrun_group_irq), .slot_empty_irq(slot_empty_irq),
        .mailbox_zero_rx_irq(mailbox_zero_rx_irq), .other_mailbox_rx_irq(other_mailbox_rx_irq),
        .dma_request(dma_request), .comm_reset(comm_reset), .test_mode(test_mode));
    // ==========
    // Bus and engine drivers
    task automatic wb(input logic [7:0] a, input logic w, input int dv, output logic [15:0] q,
        output int n);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= {16'h0000, dv[15:0]};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input int dv);
        logic [15:0] q;
        int n;
        wb(a, 1'b1, dv, q, n);
    endtask
    task automatic rd_chk(input logic [7:0] a, input int e);
        logic [15:0] q;
        int n;
        wb(a, 1'b0, 0, q, n);
        `CHK($sformatf("reg %h", a), e[15:0], q)
    endtask
    task automatic pulse(input int k, input int arg);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k[3:0];
        cmd_arg <= arg[8:0];
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    // ==========
    // Reference model
    function automatic int lv(int t, int r);
        return ((t >= 96) ? 1 : 0) | ((r >= 96) ? 2 : 0) | ((t >= 128 || r >= 128) ? 4 : 0)
            | ((t >= 256) ? 8 : 0);
    endfunction
    function automatic int fexp();
        return flags | ((rxp != 0) ? 2 : 0) | ((rmp != 0) ? 4 : 0);
    endfunction
    task automatic check_lines();
        int en;
        logic r0;
        logic r1;
        repeat (3) @(posedge sys_clk);
        en = flags & ~imask;
        r0 = ((rxp & ~mbmask & 1) != 0 && !imask[1]) || ((rmp & ~mbmask & 1) != 0 && !imask[2]);
        r1 = ((rxp & ~mbmask & 'hFFFE) != 0 && !imask[1])
            || ((rmp & ~mbmask & 'hFFFE) != 0 && !imask[2]);
        `CHK("err_irq", (en & ERR_GROUP) != 0, error_status_irq)
        `CHK("ovr_irq", (en & OVR_GROUP) != 0 || (po && flags[0]), overrun_group_irq)
        `CHK("sle_irq", (en & SLE_GROUP) != 0, slot_empty_irq)
        `CHK("rm0_irq", r0, mailbox_zero_rx_irq)
        `CHK("rm1_irq", r1, other_mailbox_rx_irq)
        `CHK("dma_req", r0, dma_request)
    endtask
    task automatic clear_flags();
        wr(IRQ_REQ_ADDR, 'hFFFF);
        flags = 0;
        po = 0;
    endtask
    // Both counters move one at a time, so a crossing seen in between also counts
    task automatic counts(input int t, input int r);
        int o;
        o = lv(txm, rxm);
        txm = t;
        pulse(10, t);
        flags |= (lv(txm, rxm) & ~o) << 3;
        o = lv(txm, rxm);
        rxm = r;
        pulse(11, r);
        flags |= (lv(txm, rxm) & ~o) << 3;
        rd_chk(GLOBAL_STAT_ADDR, lv(txm, rxm));
        rd_chk(IRQ_REQ_ADDR, fexp());
        check_lines();
        clear_flags();
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        po = 1;
        txm = 0;
        rxm = 0;
    endtask
    task automatic post(input int mc);
        logic seen;
        seen = 1'b0;
        repeat (6)
        begin
            @(posedge sys_clk);
            seen |= comm_reset;
        end
        `CHK("comm_reset", 1'b1, seen)
        flags = 1;
        imask = 'hFFFF;
        mbmask = 'hFFFF;
        rxp = 0;
        rmp = 0;
        tm = mc >> 1;
        rd_chk(MASTER_CTRL_ADDR, mc);
        `CHK("test_mode", tm[0], test_mode)
        rd_chk(IRQ_MASK_ADDR, 'hFFFF);
        rd_chk(MBOX_MASK_ADDR, 'hFFFF);
        rd_chk(IRQ_REQ_ADDR, 1);
        rd_chk(CTRL_FIELD_BASE + 8'h04, 0);
        if (pay >= 0)
            rd_chk(MBOX_DATA_BASE + 8'h04, pay);
        check_lines();
    endtask
    task automatic complete_run();
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end
    // ==========
    // Scenarios; no access before reset is over
    initial
    begin
        logic [15:0] q;
        int n;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        po = 1;
        txm = 0;
        rxm = 0;
        post(0);
        clear_flags();
        imask = 0;
        mbmask = 0;
        wr(IRQ_MASK_ADDR, 0);
        wr(MBOX_MASK_ADDR, 0);
        check_lines();
        for (int i = 0; i < 14; i++)
            counts((i < 6) ? bt[i] : {$random(seed)} % 300, (i < 6) ? br[i] : {$random(seed)} % 256);
        counts(0, 0);
        for (int m = 0; m < 2; m++)
        begin
            wr(MASTER_CTRL_ADDR, m << 1);
            tm = m;
            for (int k = 0; k < 8; k++)
            begin
                pulse(k, {$random(seed)} % 16);
                if (k != 4 || m == 1)
                    flags |= 1 << ebit[k];
                rd_chk(IRQ_REQ_ADDR, fexp());
                check_lines();
                clear_flags();
            end
        end
        wr(MASTER_CTRL_ADDR, 0);
        for (int i = 0; i < 4; i++)
        begin
            mb = (i < 2) ? 0 : 1 + {$random(seed)} % 15;
            pulse(8 + i % 2, mb);
            if (i % 2)
                rmp |= 1 << mb;
            else
                rxp |= 1 << mb;
            rd_chk(IRQ_REQ_ADDR, fexp());
            rd_chk(RX_PEND_ADDR, rxp);
            rd_chk(REMOTE_PEND_ADDR, rmp);
            check_lines();
            if (mb == 0)
                rd_chk(CTRL_FIELD_BASE, 0);
            mbmask = 1 << mb;
            wr(MBOX_MASK_ADDR, mbmask);
            check_lines();
            mbmask = 0;
            wr(MBOX_MASK_ADDR, 0);
            rxp = 0;
            rmp = 0;
            wr(RX_PEND_ADDR, 'hFFFF);
            wr(REMOTE_PEND_ADDR, 'hFFFF);
            check_lines();
        end
        imask = 'hFFFF;
        wr(IRQ_MASK_ADDR, imask);
        for (int k = 0; k < 8; k++)
        begin
            pulse(k, k);
            flags |= (k == 4) ? 0 : 1 << ebit[k];
        end
        rd_chk(IRQ_REQ_ADDR, fexp());
        check_lines();
        clear_flags();
        imask = 0;
        wr(IRQ_MASK_ADDR, 0);
        // Storage stalls are bounded; an idle store must not stall at all
        pulse(12, 1);
        d = {$random(seed)} & 'hFFFF;
        wb(MBOX_DATA_BASE + 8'h04, 1'b1, d, q, n);
        `CHK("stall", 1'b1, n >= 2 && n <= 7)
        wb(CTRL_FIELD_BASE + 8'h04, 1'b1, d ^ 'h5A5A, q, n);
        `CHK("stall", 1'b1, n >= 2 && n <= 7)
        pulse(12, 0);
        wb(MBOX_DATA_BASE + 8'h04, 1'b0, 0, q, n);
        `CHK("no_stall", 2, n)
        `CHK("payload", d[15:0], q)
        pay = d;
        rd_chk(CTRL_FIELD_BASE + 8'h04, d ^ 'h5A5A);
        wr(8'h20, 'h1234);
        rd_chk(8'h20, 0);
        wr(MASTER_CTRL_ADDR, 3);
        post(2);
        wr(IRQ_MASK_ADDR, 0);
        @(posedge sys_clk);
        standby_entry <= 1'b1;
        @(posedge sys_clk);
        standby_entry <= 1'b0;
        post(0);
        do_reset();
        post(0);
        clear_flags();
        check_lines();
        complete_run();
    end
endmodule // can_controller_interrupt_reset_logic_bench
`default_nettype wire
